/* File: core/fsrd_router.sv */
// flash space router: select priority, strobe gating and routing register
//
// Overview of operation
// - secondary flash beats main flash on overlap
// - sram, control, peripheral selects beat both flashes
// - main flash selects never overlap each other
// - secondary flash selects never overlap each other
// - sram, control, peripheral ranges kept disjoint
// - flash select not larger than its sector
// - strobes gated to each flash separately
// - reset loads routing bits from non-volatile value
// - processor may rewrite routing at run time
// - bits 4,3 open data access to flashes
// - bits 2,1 open fetch access to flashes
// - bit 7 peripheral mode, cleared on reset
// - sram and control answer data cycles only
// - routing register at control offset e2
// - byte program, whole-sector erase only
// - fetch drives 16 bits, others 8 bits
`timescale 1ns/1ps
`default_nettype none
`include "fsrd_map.svh"
module fsrd_router (
  input wire logic clk,
  input wire logic rst,
  fsrd_bus_if.device bus,
  input wire logic [7:0] nv_routing,
  input wire logic [`FSRD_N_MAIN-1:0] main_flash_sector_select,
  input wire logic [`FSRD_N_SEC-1:0] secondary_flash_sector_select,
  input wire logic sram_select,
  input wire logic ctl_select,
  input wire logic [`FSRD_N_PIO-1:0] peripheral_io_select,
  input wire logic [15:0] main_rdata,
  input wire logic [15:0] sec_rdata,
  input wire logic [7:0] sram_rdata,
  input wire logic [7:0] ctl_rdata,
  input wire logic [7:0] pio_rdata,
  output logic [`FSRD_N_MAIN-1:0] main_sel_o,
  output logic [`FSRD_N_SEC-1:0] sec_sel_o,
  output logic main_fetch_o,
  output logic main_rd_o,
  output logic main_wr_o,
  output logic sec_fetch_o,
  output logic sec_rd_o,
  output logic sec_wr_o,
  output logic sram_rd_o,
  output logic sram_wr_o,
  output logic ctl_rd_o,
  output logic ctl_wr_o,
  output logic [`FSRD_N_PIO-1:0] pio_sel_o,
  output logic pio_rd_o,
  output logic pio_wr_o,
  output logic [7:0] wdata_o,
  output logic [15:0] addr_o,
  output logic port_a_periph_io_enable,
  output var fsrd_pkg::fsrd_tgt_t target_o
);
  import fsrd_pkg::*;

  logic [7:0] space_routing_reg_r;
  logic [7:0] space_routing_reg_nxt;
  logic rst_d_r;
  fsrd_tgt_t tgt_r;
  logic wide_r;

  wire data_cyc = bus.read_strobe | bus.write_strobe;
  wire any_main = |main_flash_sector_select;
  wire any_sec = |secondary_flash_sector_select;
  wire any_pio = |peripheral_io_select;
  wire hi_sel = sram_select | ctl_select | any_pio;
  wire sec_win = any_sec & ~hi_sel;
  wire main_win = any_main & ~any_sec & ~hi_sel;
  wire ctl_hit = ctl_select & data_cyc & ~sram_select & ~any_pio;
  // the routing register sits inside the control block window
  wire reg_hit = ctl_hit & (bus.addr[7:0] == `FSRD_CTL_OFS);
  wire main_data_en = space_routing_reg_r[`FSRD_BIT_MAIN_DATA];
  wire sec_data_en = space_routing_reg_r[`FSRD_BIT_SEC_DATA];
  wire main_prog_en = space_routing_reg_r[`FSRD_BIT_MAIN_PROG];
  wire sec_prog_en = space_routing_reg_r[`FSRD_BIT_SEC_PROG];
  wire main_f = main_win & bus.fetch_strobe & main_prog_en;
  wire main_r = main_win & bus.read_strobe & main_data_en;
  wire main_w = main_win & bus.write_strobe & main_data_en;
  wire sec_f = sec_win & bus.fetch_strobe & sec_prog_en;
  wire sec_r = sec_win & bus.read_strobe & sec_data_en;
  wire sec_w = sec_win & bus.write_strobe & sec_data_en;
  wire sram_r = sram_select & bus.read_strobe;
  wire sram_w = sram_select & bus.write_strobe;
  wire pio_r = any_pio & bus.read_strobe & ~sram_select;
  wire pio_w = any_pio & bus.write_strobe & ~sram_select;

  // one target per cycle, highest priority level first
  wire fsrd_tgt_t tgt_now =
    (sram_r | sram_w) ? FSRD_TGT_SRAM :
    ctl_hit ? FSRD_TGT_CTL :
    (pio_r | pio_w) ? FSRD_TGT_PIO :
    (sec_f | sec_r | sec_w) ? FSRD_TGT_SEC :
    (main_f | main_r | main_w) ? FSRD_TGT_MAIN : FSRD_TGT_NONE;

  always_comb begin
    space_routing_reg_nxt = space_routing_reg_r;
    if (rst_d_r) begin
      space_routing_reg_nxt = nv_routing & `FSRD_NV_MASK;
    end else if (reg_hit && bus.write_strobe) begin
      space_routing_reg_nxt = bus.wdata & `FSRD_ROUTE_MASK;
    end
  end

  // strap is caught by a clocked load in the cycle after reset release
  always_ff @(posedge clk) begin
    rst_d_r <= rst;
    if (rst) begin
      space_routing_reg_r <= 8'h00;
    end else begin
      space_routing_reg_r <= space_routing_reg_nxt;
    end
  end

  // registered strobes: a flash programs one byte per write cycle and
  // erase is only a sector command issued through that byte path
  always_ff @(posedge clk) begin
    if (rst) begin
      main_sel_o <= '0;
      sec_sel_o <= '0;
      main_fetch_o <= 1'b0;
      main_rd_o <= 1'b0;
      main_wr_o <= 1'b0;
      sec_fetch_o <= 1'b0;
      sec_rd_o <= 1'b0;
      sec_wr_o <= 1'b0;
      sram_rd_o <= 1'b0;
      sram_wr_o <= 1'b0;
      ctl_rd_o <= 1'b0;
      ctl_wr_o <= 1'b0;
      pio_sel_o <= '0;
      pio_rd_o <= 1'b0;
      pio_wr_o <= 1'b0;
      wdata_o <= 8'h00;
      addr_o <= 16'h0000;
      port_a_periph_io_enable <= 1'b0;
      target_o <= FSRD_TGT_NONE;
    end else begin
      main_sel_o <= main_win ? main_flash_sector_select : '0;
      sec_sel_o <= sec_win ? secondary_flash_sector_select : '0;
      main_fetch_o <= main_f;
      main_rd_o <= main_r;
      main_wr_o <= main_w;
      sec_fetch_o <= sec_f;
      sec_rd_o <= sec_r;
      sec_wr_o <= sec_w;
      sram_rd_o <= sram_r;
      sram_wr_o <= sram_w;
      ctl_rd_o <= ctl_hit & bus.read_strobe & ~reg_hit;
      ctl_wr_o <= ctl_hit & bus.write_strobe & ~reg_hit;
      pio_sel_o <= peripheral_io_select;
      pio_rd_o <= pio_r;
      pio_wr_o <= pio_w;
      wdata_o <= bus.wdata;
      addr_o <= bus.addr;
      port_a_periph_io_enable <= space_routing_reg_r[`FSRD_BIT_PIO];
      target_o <= tgt_now;
    end
  end

  // read path: data stands one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_r <= FSRD_TGT_NONE;
      wide_r <= 1'b0;
    end else begin
      tgt_r <= reg_hit ? FSRD_TGT_NONE : tgt_now;
      wide_r <= bus.fetch_strobe & (main_f | sec_f);
    end
  end

  logic reg_rd_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rd_r <= 1'b0;
    end else begin
      reg_rd_r <= reg_hit & bus.read_strobe;
    end
  end

  always_comb begin
    bus.rdata = 16'h0000;
    bus.wide = wide_r;
    if (reg_rd_r) begin
      bus.rdata = {8'h00, space_routing_reg_r};
    end else begin
      case (tgt_r)
        FSRD_TGT_MAIN: bus.rdata = wide_r ? main_rdata : {8'h00, main_rdata[7:0]};
        FSRD_TGT_SEC: bus.rdata = wide_r ? sec_rdata : {8'h00, sec_rdata[7:0]};
        FSRD_TGT_SRAM: bus.rdata = {8'h00, sram_rdata};
        FSRD_TGT_CTL: bus.rdata = {8'h00, ctl_rdata};
        FSRD_TGT_PIO: bus.rdata = {8'h00, pio_rdata};
        default: bus.rdata = 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: core/fsrd_map.svh */
// register offsets, field positions and widths for the flash space router
`ifndef FSRD_MAP_SVH
`define FSRD_MAP_SVH
`define FSRD_ADDR_W 16
`define FSRD_CTL_OFS 8'he2
`define FSRD_BIT_PIO 7
`define FSRD_BIT_MAIN_DATA 4
`define FSRD_BIT_SEC_DATA 3
`define FSRD_BIT_MAIN_PROG 2
`define FSRD_BIT_SEC_PROG 1
`define FSRD_ROUTE_MASK 8'h9e
`define FSRD_NV_MASK 8'h1e
`define FSRD_N_MAIN 8
`define FSRD_N_SEC 4
`define FSRD_N_PIO 2
`define FSRD_RESET_NV 8'h0c
`endif

/* File: core/fsrd_pkg.sv */
// types shared by the flash space router and its bus master
package fsrd_pkg;
  typedef enum logic [1:0] {
    FSRD_CYC_NONE,
    FSRD_CYC_FETCH,
    FSRD_CYC_READ,
    FSRD_CYC_WRITE
  } fsrd_cyc_t;
  typedef enum logic [2:0] {
    FSRD_TGT_NONE,
    FSRD_TGT_MAIN,
    FSRD_TGT_SEC,
    FSRD_TGT_SRAM,
    FSRD_TGT_CTL,
    FSRD_TGT_PIO
  } fsrd_tgt_t;
endpackage

/* File: core/fsrd_bus_if.sv */
// processor-bus interface between the core master and the space router
`timescale 1ns/1ps
`default_nettype none
interface fsrd_bus_if;
  logic [15:0] addr;
  logic fetch_strobe;
  logic read_strobe;
  logic write_strobe;
  logic [7:0] wdata;
  logic [15:0] rdata;
  logic wide;
  modport device (
    input addr, fetch_strobe, read_strobe, write_strobe, wdata,
    output rdata, wide
  );
  modport core (
    output addr, fetch_strobe, read_strobe, write_strobe, wdata,
    input rdata, wide
  );
endinterface
`default_nettype wire

/* File: core/fsrd_core_master.sv */
// processor-side bus master: turns user requests into one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "fsrd_map.svh"
module fsrd_core_master (
  input wire logic clk,
  input wire logic rst,
  fsrd_bus_if.core bus,
  input wire logic req_valid,
  input wire fsrd_pkg::fsrd_cyc_t req_kind,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic resp_wide
);
  import fsrd_pkg::*;

  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic fetch_r;
  logic read_r;
  logic write_r;
  logic pend_r;
  logic pend_d_r;

  // one strobe per request; the decode configuration that drives the
  // selects keeps flash ranges within sectors and free of same-level
  // overlap
  wire go = req_valid & (req_kind != FSRD_CYC_NONE);
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      fetch_r <= 1'b0;
      read_r <= 1'b0;
      write_r <= 1'b0;
      pend_r <= 1'b0;
      pend_d_r <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= 16'h0000;
      resp_wide <= 1'b0;
    end else begin
      addr_r <= go ? req_addr : addr_r;
      wdata_r <= go ? req_wdata : wdata_r;
      fetch_r <= go & (req_kind == FSRD_CYC_FETCH);
      read_r <= go & (req_kind == FSRD_CYC_READ);
      write_r <= go & (req_kind == FSRD_CYC_WRITE);
      pend_r <= go & (req_kind != FSRD_CYC_WRITE);
      // read data stand only in the cycle after the strobe
      pend_d_r <= pend_r;
      resp_valid <= pend_d_r;
      resp_data <= pend_d_r ? bus.rdata : resp_data;
      resp_wide <= pend_d_r ? bus.wide : resp_wide;
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.fetch_strobe = fetch_r;
  assign bus.read_strobe = read_r;
  assign bus.write_strobe = write_r;
endmodule
`default_nettype wire

/* File: verif/fsrd_assertions.sv */
// concurrent checks on the processor bus and the router strobe outputs
`timescale 1ns/1ps
`default_nettype none
module fsrd_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_strobe,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] main_sel_o,
  input wire logic [3:0] sec_sel_o,
  input wire logic [1:0] pio_sel_o,
  input wire logic main_wr_o,
  input wire logic sec_wr_o,
  input wire logic wide,
  input wire logic main_fetch_o,
  input wire logic main_rd_o,
  input wire logic sec_fetch_o,
  input wire logic sec_rd_o,
  input wire logic sram_rd_o,
  input wire logic ctl_rd_o,
  input wire logic pio_rd_o,
  input wire logic port_a_periph_io_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_fetch_hit;
    fetch_strobe ##1 (main_fetch_o || sec_fetch_o);
  endsequence
  a_sec_over_main: assert property ((sec_fetch_o || sec_rd_o) |->
    !(main_fetch_o || main_rd_o)) else $error("main flash answered too");
  a_high_blocks_flash: assert property ((sram_rd_o || ctl_rd_o || pio_rd_o)
    |-> !(main_rd_o || sec_rd_o)) else $error("flash read not blocked");
  a_one_target: assert property ($onehot0({main_rd_o, sec_rd_o,
    sram_rd_o, ctl_rd_o, pio_rd_o})) else $error("two read targets at once");
  a_fetch_cause: assert property ((main_fetch_o || sec_fetch_o) |->
    $past(fetch_strobe)) else $error("flash fetch without a fetch");
  a_read_cause: assert property ((main_rd_o || sec_rd_o) |->
    $past(read_strobe)) else $error("flash read without a read");
  a_no_fetch_data: assert property (fetch_strobe |=>
    !(sram_rd_o || ctl_rd_o)) else $error("data target took a fetch");
  a_wide_fetch: assert property (s_fetch_hit |-> wide)
    else $error("flash fetch not wide");
  a_pio_reset: assert property ($fell(rst) |->
    !port_a_periph_io_enable [*2]) else $error("port mode set after reset");
  a_main_sel_live: assert property ((main_fetch_o || main_rd_o ||
    main_wr_o) |-> main_sel_o != 8'h00)
    else $error("main strobe without select");
  a_sec_sel_quiet: assert property ((sec_sel_o != 4'h0) |->
    main_sel_o == 8'h00) else $error("both flash selects passed");
  a_pio_sel_live: assert property (pio_rd_o |-> pio_sel_o != 2'h0)
    else $error("peripheral read without select");
  a_flash_wr_cause: assert property ((main_wr_o || sec_wr_o) |->
    $past(write_strobe)) else $error("flash write without a write");
endmodule
`default_nettype wire

/* File: verif/flash_space_routing_decode_bench.sv */
// self-checking bench: core master and router joined on the processor bus
`timescale 1ns/1ps
`default_nettype none
module flash_space_routing_decode_bench;
  import fsrd_pkg::*;
  typedef struct {
    fsrd_cyc_t k;
    logic [15:0] ad;
    logic [7:0] wd;
    logic [15:0] ex;
    logic w;
    fsrd_tgt_t t;
  } fsrd_row_t;
  localparam fsrd_cyc_t fe = FSRD_CYC_FETCH;
  localparam fsrd_cyc_t rd = FSRD_CYC_READ;
  localparam fsrd_cyc_t wr = FSRD_CYC_WRITE;
  // routing starts as the strap value f3 masked to 12
  fsrd_row_t rows[18] = '{
    '{rd, 16'h20e2, 8'h00, 16'h0012, 1'b0, FSRD_TGT_CTL},
    '{rd, 16'h4000, 8'h00, 16'h0034, 1'b0, FSRD_TGT_MAIN},
    '{fe, 16'h4000, 8'h00, 16'h0000, 1'b0, FSRD_TGT_NONE},
    '{fe, 16'ha000, 8'h00, 16'h5678, 1'b1, FSRD_TGT_SEC},
    '{rd, 16'h1000, 8'h00, 16'h009a, 1'b0, FSRD_TGT_SRAM},
    '{wr, 16'h4000, 8'h55, 16'h0000, 1'b0, FSRD_TGT_MAIN},
    '{wr, 16'ha000, 8'h66, 16'h0000, 1'b0, FSRD_TGT_NONE},
    '{wr, 16'h20e2, 8'hff, 16'h0000, 1'b0, FSRD_TGT_CTL},
    '{rd, 16'h20e2, 8'h00, 16'h009e, 1'b0, FSRD_TGT_CTL},
    '{fe, 16'h4000, 8'h00, 16'h1234, 1'b1, FSRD_TGT_MAIN},
    '{rd, 16'ha000, 8'h00, 16'h0078, 1'b0, FSRD_TGT_SEC},
    '{fe, 16'h1000, 8'h00, 16'h0000, 1'b0, FSRD_TGT_NONE},
    '{rd, 16'h2010, 8'h00, 16'h00bc, 1'b0, FSRD_TGT_CTL},
    '{rd, 16'h2100, 8'h00, 16'h00de, 1'b0, FSRD_TGT_PIO},
    '{wr, 16'h20e2, 8'h00, 16'h0000, 1'b0, FSRD_TGT_CTL},
    '{rd, 16'h4000, 8'h00, 16'h0000, 1'b0, FSRD_TGT_NONE},
    '{fe, 16'ha000, 8'h00, 16'h0000, 1'b0, FSRD_TGT_NONE},
    '{rd, 16'h20e2, 8'h00, 16'h0000, 1'b0, FSRD_TGT_CTL}};
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, resp_valid, resp_wide;
  fsrd_cyc_t req_kind = FSRD_CYC_NONE;
  logic [15:0] req_addr = 16'h0, resp_data, d;
  logic [15:0] main_rdata = 16'h1234, sec_rdata = 16'h5678;
  logic [7:0] req_wdata = 8'h0, nv_routing = 8'hf3, sram_rdata = 8'h9a;
  logic [7:0] ctl_rdata = 8'hbc, pio_rdata = 8'hde;
  logic [7:0] main_flash_sector_select;
  logic [3:0] secondary_flash_sector_select;
  logic [1:0] peripheral_io_select;
  logic sram_select, ctl_select, main_rd_o, main_fetch_o, sec_rd_o, w;
  logic sec_fetch_o, sram_rd_o, ctl_rd_o, pio_rd_o, port_a_periph_io_enable;
  logic main_wr_o, sec_wr_o;
  logic [7:0] main_sel_o, wdata_o, wo;
  logic [3:0] sec_sel_o;
  logic [1:0] pio_sel_o, st, ew;
  logic [15:0] addr_o, ao;
  fsrd_tgt_t target_o, tg;
  int mismatches = 0, n_compared = 0;
  fsrd_bus_if bus ();
  always #5 clk = ~clk;
  // map: sram and control low, secondary flash over the upper main half
  wire [15:0] a = bus.addr;
  assign main_flash_sector_select = 8'h1 << a[15:13];
  assign secondary_flash_sector_select =
    a[15] ? 4'h1 << a[14:13] : 4'h0;
  assign sram_select = a < 16'h2000;
  assign ctl_select = a[15:8] == 8'h20;
  assign peripheral_io_select = {a[15:8] == 8'h22, a[15:8] == 8'h21};
  fsrd_core_master fsrd_core_master_i (.clk, .rst, .bus(bus.core), .req_valid,
    .req_kind, .req_addr, .req_wdata, .resp_valid, .resp_data, .resp_wide);
  fsrd_router fsrd_router_i (.clk, .rst, .bus(bus.device), .nv_routing,
    .main_flash_sector_select, .secondary_flash_sector_select, .sram_select,
    .ctl_select, .peripheral_io_select, .main_rdata, .sec_rdata, .sram_rdata,
    .ctl_rdata, .pio_rdata, .main_sel_o, .sec_sel_o, .main_fetch_o,
    .main_rd_o, .main_wr_o, .sec_fetch_o, .sec_rd_o, .sec_wr_o, .sram_rd_o,
    .sram_wr_o(), .ctl_rd_o, .ctl_wr_o(), .pio_sel_o, .pio_rd_o, .pio_wr_o(),
    .wdata_o, .addr_o, .port_a_periph_io_enable, .target_o);
  fsrd_assertions fsrd_assertions_i (.clk, .rst,
    .fetch_strobe(bus.fetch_strobe), .read_strobe(bus.read_strobe),
    .write_strobe(bus.write_strobe), .main_sel_o, .sec_sel_o, .pio_sel_o,
    .main_wr_o, .sec_wr_o,
    .wide(bus.wide), .main_fetch_o, .main_rd_o, .sec_fetch_o, .sec_rd_o,
    .sram_rd_o, .ctl_rd_o, .pio_rd_o, .port_a_periph_io_enable);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic drive(fsrd_cyc_t k, logic [15:0] ad, logic [7:0] wd);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= ad;
    req_wdata <= wd;
  endtask
  task automatic txn(fsrd_cyc_t k, logic [15:0] ad, logic [7:0] wd);
    int i;
    tg = FSRD_TGT_NONE;
    @(posedge clk);
    drive(k, ad, wd);
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (i == 0) begin
        ao = addr_o;
        wo = wdata_o;
        st = {main_wr_o, sec_wr_o};
      end
      if (target_o != FSRD_TGT_NONE) tg = target_o;
      if (resp_valid === 1'b1 || (k == wr && i == 2)) break;
    end
    if (i == 8) begin
      check("resp_valid", 16'h0, 16'h1);
      test_done();
    end
  endtask
  task automatic do_reset(logic [7:0] nv);
    @(posedge clk);
    rst <= 1'b1;
    nv_routing <= nv;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("port_a", {15'h0, port_a_periph_io_enable}, 16'h0);
  endtask
  initial begin
    do_reset(8'hf3);
    foreach (rows[i]) begin
      txn(rows[i].k, rows[i].ad, rows[i].wd);
      ew = {rows[i].k == wr && rows[i].t == FSRD_TGT_MAIN,
        rows[i].k == wr && rows[i].t == FSRD_TGT_SEC};
      check("target", {13'h0, tg}, {13'h0, rows[i].t});
      check("addr_o", ao, rows[i].ad);
      check("wdata_o", {8'h00, wo}, {8'h00, rows[i].wd});
      check("flash_wr", {14'h0, st}, {14'h0, ew});
      if (rows[i].k != wr) begin
        check("resp_data", resp_data, rows[i].ex);
        check("resp_wide", {15'h0, resp_wide}, {15'h0, rows[i].w});
      end
      $display("row %0d done", i);
    end
    // routing write followed at once by a fetch that needs the new value
    d = 16'hffff;
    @(posedge clk);
    drive(wr, 16'h20e2, 8'h86);
    @(posedge clk);
    drive(fe, 16'h4000, 8'h0);
    repeat (5) begin
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      if (resp_valid === 1'b1) begin
        d = resp_data;
        w = resp_wide;
      end
    end
    check("fetch_data", d, 16'h1234);
    check("fetch_wide", {15'h0, w}, 16'h1);
    check("port_a", {15'h0, port_a_periph_io_enable}, 16'h1);
    $display("back to back done");
    do_reset(8'h0c);
    txn(rd, 16'h20e2, 8'h0);
    check("reload", resp_data, 16'h000c);
    $display("second reset done");
    test_done();
  end
endmodule
`default_nettype wire
